// *** design/ecc_log_store.sv ***
// three seven-bit words holding the latched failing address halves and syndrome
// assumes the owner gives a word select that is stable between writes
`timescale 1ns/1ps
module ecc_log_store
  import ecc_log_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // write side
  input wire log_write_type wr,
  // read side
  input wire logic [1:0] rd_sel,
  output logic [MF_WIDTH-1:0] rd_data_ff
);
  logic [MF_WIDTH-1:0] word_ff [3];

  // contents survive reset, as the multifunction bits do
  always_ff @(posedge sys_clk) begin
    if (wr.we[0]) begin
      word_ff[0] <= wr.low;
    end
    if (wr.we[1]) begin
      word_ff[1] <= wr.high;
    end
    if (wr.we[2]) begin
      word_ff[2] <= wr.syn;
    end
  end

  // registered read; the unused select reads zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_ff <= MF_ZERO;
    end else if (rd_sel == LOG_NONE) begin
      rd_data_ff <= MF_ZERO;
    end else begin
      rd_data_ff <= word_ff[rd_sel];
    end
  end
endmodule

// *** design/ecc_memory_error_logging.sv ***
// error-logging part of the ecc memory control/status register
// assumes host register cycles and memory access events are synchronous to sys_clk
//
// Operation
// - set inhibit with pointer 0 keeps first 16k words under full ecc
// - single flag sets on single error with effective correction enabled
// - bits 5-11 hold check bits or log views, writable except in the syndrome view, kept over reset
// - normal mode errors latch failing address and syndrome bits, except corrected singles while uncorrectable is set
// - normal mode, half select 0, read returns address bits 11-17
// - normal mode, half select 1, read returns bits 18-21 and bit 1
// - diagnostic with half select 1 returns syndrome, overall parity first
// - set inhibit enables pointer; clear means modes cover all memory
// - half select picks low address half or high half plus bit 1
// - diagnostic read with half select 0 stores array check bits, diagnostic write uses them
// - uncorrectable flag sets on double error, or any error without correction
`timescale 1ns/1ps
module ecc_memory_error_logging
  import ecc_log_pkg::*;
(
  // clock and reset (power-up and bus initialise both drive resetn)
  input wire logic sys_clk,
  input wire logic resetn,
  // host register cycles
  input wire logic bus_read_cycle,
  input wire logic bus_write_cycle,
  input wire logic [15:0] csr_wdata,
  output logic [15:0] csr_rdata_ff,
  output logic csr_rvalid_ff,
  // memory access start, address of the word
  input wire logic acc_start,
  input wire logic acc_write,
  input wire logic [21:1] acc_addr,
  // mode applied to the started access
  output logic eff_corr_disable_ff,
  output logic eff_diag_ff,
  output logic [CHECK_WIDTH-1:0] wr_check_ff,
  // memory access completion from the ecc datapath
  input wire logic acc_done,
  input wire ecc_result_type acc_result
);
  // control bits
  logic corr_disable_ff;
  logic diag_ff;
  logic ptr_ff;
  logic single_ff;
  logic set_inhibit_ff;
  logic half_ff;
  logic uncorr_ff;
  // multifunction bits in their check-bit view
  logic [MF_WIDTH-1:0] mf_ff;
  // access in flight
  logic [21:1] cur_addr_ff;
  logic cur_write_ff;
  // log store
  log_write_type nxt_log;
  logic [1:0] view_sel;
  logic [MF_WIDTH-1:0] log_rdata_ff;
  // event decode
  logic log_ok;
  logic set_single;
  logic set_uncorr;
  logic any_err;

  // word lies in the block named by the pointer while set inhibit is on
  function automatic logic is_protected(input logic [21:1] a, input logic inh,
                                        input logic ptr);
    is_protected = inh && (a[21:16] == UPPER_ZERO) && (a[BLOCK_BIT] == ptr);
  endfunction

  // which view bits 5-11 show for the current mode bits
  function automatic logic [1:0] view_of(input logic diag, input logic half);
    if (!diag && !half) begin
      view_of = LOG_LOW;
    end else if (!diag) begin
      view_of = LOG_HIGH;
    end else if (half) begin
      view_of = LOG_SYN;
    end else begin
      view_of = LOG_NONE;
    end
  endfunction

  assign view_sel = view_of(diag_ff, half_ff);

  // inhibit gates pointer
  // the mode is fixed at access start so a mid-access register write cannot split it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      eff_corr_disable_ff <= 1'b0;
      eff_diag_ff <= 1'b0;
      cur_addr_ff <= '0;
      cur_write_ff <= 1'b0;
    end else if (acc_start) begin
      eff_corr_disable_ff <= corr_disable_ff && !is_protected(acc_addr, set_inhibit_ff, ptr_ff);
      eff_diag_ff <= diag_ff && !is_protected(acc_addr, set_inhibit_ff, ptr_ff);
      cur_addr_ff <= acc_addr;
      cur_write_ff <= acc_write;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_check_ff <= '0;
    end else if (acc_start) begin
      wr_check_ff <= mf_ff[CHECK_WIDTH-1:0];
    end
  end

  // event decode for the finishing access
  always_comb begin
    any_err = acc_result.single_err || acc_result.double_err;
    set_single = acc_done && acc_result.single_err && !eff_corr_disable_ff;
    set_uncorr = acc_done && (acc_result.double_err
                 || (acc_result.single_err && eff_corr_disable_ff));
    // with correction on, a single error leaves an earlier double error log alone
    log_ok = acc_done && !eff_diag_ff && any_err
             && (acc_result.double_err || eff_corr_disable_ff || !uncorr_ff);
  end

  // log store writes from hardware logging or normal-mode host writes of bits 5-11
  always_comb begin
    nxt_log = '0;
    if (log_ok) begin
      nxt_log.we = 3'h7;
      nxt_log.low = cur_addr_ff[17:11];
      nxt_log.high = {2'b00, cur_addr_ff[1], cur_addr_ff[21:18]};
      // overall parity syndrome first
      // overall parity lands in bit 5, the lowest view bit, as a11 and a18 do
      nxt_log.syn = {1'b0, acc_result.syndrome};
    end else if (bus_write_cycle && !diag_ff) begin
      nxt_log.low = csr_wdata[MF_MSB:MF_LSB];
      nxt_log.high = {2'b00, csr_wdata[MF_LSB+4:MF_LSB]};
      if (half_ff) begin
        nxt_log.we = 3'h2;
      end else begin
        nxt_log.we = 3'h1;
      end
    end
  end

  ecc_log_store u_log (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .wr(nxt_log),
    .rd_sel(view_sel),
    .rd_data_ff(log_rdata_ff)
  );

  always_ff @(posedge sys_clk) begin
    if (acc_done && eff_diag_ff && !cur_write_ff && !half_ff) begin
      mf_ff <= {1'b0, acc_result.array_check};
    end else if (bus_write_cycle && diag_ff && !half_ff) begin
      // with half select set the syndrome view takes no diagnostic data
      mf_ff <= csr_wdata[MF_MSB:MF_LSB];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      corr_disable_ff <= CSR_RESET[BIT_CORR_DISABLE];
      diag_ff <= CSR_RESET[BIT_DIAG];
      ptr_ff <= CSR_RESET[BIT_PTR];
      set_inhibit_ff <= CSR_RESET[BIT_SET_INHIBIT];
      half_ff <= CSR_RESET[BIT_HALF];
    end else if (bus_write_cycle) begin
      corr_disable_ff <= csr_wdata[BIT_CORR_DISABLE];
      diag_ff <= csr_wdata[BIT_DIAG];
      ptr_ff <= csr_wdata[BIT_PTR];
      set_inhibit_ff <= csr_wdata[BIT_SET_INHIBIT];
      half_ff <= csr_wdata[BIT_HALF];
    end
  end

  // single error flag
  // a hardware set in the same cycle as a host write wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      single_ff <= CSR_RESET[BIT_SINGLE];
    end else if (set_single) begin
      single_ff <= 1'b1;
    end else if (bus_write_cycle) begin
      single_ff <= csr_wdata[BIT_SINGLE];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      uncorr_ff <= CSR_RESET[BIT_UNCORR];
    end else if (set_uncorr) begin
      uncorr_ff <= 1'b1;
    end else if (bus_write_cycle) begin
      uncorr_ff <= csr_wdata[BIT_UNCORR];
    end
  end

  // half select multiplex
  // read data is sampled one edge after the read strobe; the log view can lag one cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      csr_rdata_ff <= CSR_RESET;
      csr_rvalid_ff <= 1'b0;
    end else begin
      csr_rvalid_ff <= bus_read_cycle;
      if (bus_read_cycle) begin
        csr_rdata_ff <= '0;
        csr_rdata_ff[BIT_CORR_DISABLE] <= corr_disable_ff;
        csr_rdata_ff[BIT_DIAG] <= diag_ff;
        csr_rdata_ff[BIT_PTR] <= ptr_ff;
        csr_rdata_ff[BIT_SINGLE] <= single_ff;
        csr_rdata_ff[BIT_SET_INHIBIT] <= set_inhibit_ff;
        csr_rdata_ff[BIT_HALF] <= half_ff;
        csr_rdata_ff[BIT_UNCORR] <= uncorr_ff;
        if (view_sel == LOG_NONE) begin
          csr_rdata_ff[MF_MSB:MF_LSB] <= mf_ff;
        end else begin
          csr_rdata_ff[MF_MSB:MF_LSB] <= log_rdata_ff;
        end
      end
    end
  end
endmodule

// *** shared/ecc_log_pkg.sv ***
// package for the error-logging control/status register of an ecc memory
// assumes a 22-bit byte address with word bits 21..1 and 6 check bits per word
package ecc_log_pkg;
  // control/status bit positions
  localparam int unsigned BIT_CORR_DISABLE = 1;
  localparam int unsigned BIT_DIAG = 2;
  localparam int unsigned BIT_PTR = 3;
  localparam int unsigned BIT_SINGLE = 4;
  localparam int unsigned MF_LSB = 5;
  localparam int unsigned MF_MSB = 11;
  localparam int unsigned BIT_SET_INHIBIT = 13;
  localparam int unsigned BIT_HALF = 14;
  localparam int unsigned BIT_UNCORR = 15;
  localparam int unsigned MF_WIDTH = 7;
  localparam int unsigned CHECK_WIDTH = 6;
  // bit 0 and bit 12 hold nothing here and read as zero
  localparam logic [15:0] CSR_RESET = 16'h0000;
  localparam logic [MF_WIDTH-1:0] MF_ZERO = 7'h00;
  // a 16k-word block spans byte address bits 14 and below; bit 15 picks the block
  localparam int unsigned BLOCK_BIT = 15;
  localparam logic [5:0] UPPER_ZERO = 6'h00;
  // log store entries
  localparam logic [1:0] LOG_LOW = 2'h0;
  localparam logic [1:0] LOG_HIGH = 2'h1;
  localparam logic [1:0] LOG_SYN = 2'h2;
  localparam logic [1:0] LOG_NONE = 2'h3;

  // one finished memory access as seen by the ecc datapath
  typedef struct packed {
    logic single_err;
    logic double_err;
    logic [CHECK_WIDTH-1:0] array_check;
    logic [CHECK_WIDTH-1:0] syndrome;
  } ecc_result_type;

  // one write of the three log entries
  typedef struct packed {
    logic [2:0] we;
    logic [MF_WIDTH-1:0] low;
    logic [MF_WIDTH-1:0] high;
    logic [MF_WIDTH-1:0] syn;
  } log_write_type;
endpackage

// *** tb/ecc_datapath_model.sv ***
// ecc datapath stand-in: answers each access start with a result
// assumes one access in flight; the bench picks the result
`timescale 1ns/1ps
module ecc_datapath_model
  import ecc_log_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // access start and chosen result
  input wire logic acc_start,
  input wire ecc_result_type inj,
  // completion
  output logic acc_done,
  output ecc_result_type acc_result
);
  logic [1:0] cnt_ff;
  // done three cycles after start; the result churns outside done
  // so a stale value is never taken for a fresh one
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 2'h0;
      acc_done <= 1'b0;
      acc_result <= '0;
    end else begin
      acc_done <= 1'b0;
      acc_result <= ~acc_result;
      if (acc_start) begin
        cnt_ff <= 2'h2;
      end else if (cnt_ff != 2'h0) begin
        cnt_ff <= cnt_ff - 2'h1;
        if (cnt_ff == 2'h1) begin
          acc_done <= 1'b1;
          acc_result <= inj;
        end
      end
    end
  end
endmodule

// *** tb/ecc_log_checker.sv ***
// port checker for the error-logging register
// assumes one clock domain, bound to the design top
`timescale 1ns/1ps
module ecc_log_checker
  import ecc_log_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // host and access side
  input wire logic bus_read_cycle,
  input wire logic bus_write_cycle,
  input wire logic [15:0] csr_wdata,
  input wire logic [15:0] csr_rdata_ff,
  input wire logic csr_rvalid_ff,
  input wire logic acc_start,
  input wire logic [21:1] acc_addr,
  input wire logic eff_corr_disable_ff,
  input wire logic eff_diag_ff,
  input wire logic acc_done,
  input wire ecc_result_type acc_result
);
  logic [15:0] ctl_ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // shadow of software control bits
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_ff <= 16'h0000;
    end else if (bus_write_cycle) begin
      ctl_ff <= csr_wdata;
    end
  end
  read_answer_a:
    assert property (bus_read_cycle |=> csr_rvalid_ff) else $error("read not answered");
  read_pulse_a:
    assert property (!bus_read_cycle |=> !csr_rvalid_ff) else $error("stray read valid");
  ctrl_readback_a:
    assert property (bus_read_cycle |=> csr_rdata_ff[14:13] == $past(ctl_ff[14:13])
      && csr_rdata_ff[3:1] == $past(ctl_ff[3:1])) else $error("control bits wrong");
  protect_block_a:
    assert property (acc_start && !bus_write_cycle && ctl_ff[13] && acc_addr[21:16] == 6'h00
      && acc_addr[15] == ctl_ff[3] |=> !eff_corr_disable_ff && !eff_diag_ff)
      else $error("protected word left unprotected");
  whole_memory_a:
    assert property (acc_start && !bus_write_cycle && !ctl_ff[13] |=>
      eff_diag_ff == $past(ctl_ff[2]) && eff_corr_disable_ff == $past(ctl_ff[1]))
      else $error("mode not applied");
  single_flag_a:
    assert property (acc_done && acc_result.single_err && !acc_result.double_err
      && !eff_corr_disable_ff ##1 !bus_write_cycle ##1 bus_read_cycle && !bus_write_cycle
      |=> csr_rdata_ff[4]) else $error("single flag not set");
  uncorr_double_a:
    assert property (acc_done && acc_result.double_err ##1 !bus_write_cycle
      ##1 bus_read_cycle && !bus_write_cycle |=> csr_rdata_ff[15]) else $error("double missed");
  uncorr_nocorr_a:
    assert property (acc_done && acc_result.single_err && eff_corr_disable_ff ##1 !bus_write_cycle
      ##1 bus_read_cycle && !bus_write_cycle |=> csr_rdata_ff[15]) else $error("single missed");
endmodule

bind ecc_memory_error_logging ecc_log_checker chk (.sys_clk, .resetn, .bus_read_cycle,
  .bus_write_cycle, .csr_wdata, .csr_rdata_ff, .csr_rvalid_ff, .acc_start, .acc_addr,
  .eff_corr_disable_ff, .eff_diag_ff, .acc_done, .acc_result);

// *** tb/ecc_memory_error_logging_tb_top.sv ***
// self-checking bench for the error-logging register
// assumes the datapath model answers every access start
`timescale 1ns/1ps
module ecc_memory_error_logging_tb_top
  import ecc_log_pkg::*;
;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic bus_read_cycle = 1'b0;
  logic bus_write_cycle = 1'b0;
  logic [15:0] csr_wdata = 16'h0000;
  logic acc_start = 1'b0;
  logic acc_write = 1'b0;
  logic [21:1] acc_addr = 21'h000000;
  logic [21:1] a = 21'h1b5a5a;
  logic [15:0] csr_rdata_ff;
  logic csr_rvalid_ff, eff_corr_disable_ff, eff_diag_ff, acc_done;
  logic [5:0] wr_check_ff;
  ecc_result_type inj = '0;
  ecc_result_type acc_result;
  int fails = 0;
  int cmp_count = 0;
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  ecc_memory_error_logging dut (.sys_clk, .resetn, .bus_read_cycle, .bus_write_cycle,
    .csr_wdata, .csr_rdata_ff, .csr_rvalid_ff, .acc_start, .acc_write, .acc_addr,
    .eff_corr_disable_ff, .eff_diag_ff, .wr_check_ff, .acc_done, .acc_result);
  ecc_datapath_model model (.sys_clk, .resetn, .acc_start, .inj, .acc_done, .acc_result);
  // verdict and end of run
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [15:0] d);
    @(posedge sys_clk) #1;
    bus_write_cycle = 1'b1;
    csr_wdata = d;
    @(posedge sys_clk) #1;
    bus_write_cycle = 1'b0;
  endtask
  task automatic rd(logic [15:0] mask, logic [15:0] exp, string name);
    @(posedge sys_clk) #1;
    bus_read_cycle = 1'b1;
    @(posedge sys_clk) #1;
    bus_read_cycle = 1'b0;
    chk("read valid", 16'h0001, {15'h0, csr_rvalid_ff});
    chk(name, exp, csr_rdata_ff & mask);
  endtask
  // one access; mode seen one cycle after start, then wait for done
  task automatic acc(logic [21:1] ad, logic w, ecc_result_type r, logic [1:0] e);
    int n;
    @(posedge sys_clk) #1;
    acc_start = 1'b1;
    acc_addr = ad;
    acc_write = w;
    inj = r;
    @(posedge sys_clk) #1;
    acc_start = 1'b0;
    chk("mode", {14'h0, e}, {14'h0, eff_corr_disable_ff, eff_diag_ff});
    n = 0;
    while (acc_done !== 1'b1 && n < 10) begin
      @(posedge sys_clk) #1;
      n++;
    end
    if (acc_done !== 1'b1) begin
      fails++;
      end_sim();
    end
    @(posedge sys_clk) #1;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 resetn = 1'b1;
    rd(16'hf01f, 16'h0000, "reset value");
    wr(16'hf01f);
    rd(16'hf01f, 16'he01e, "control");
    $display("control test done");
    // each pointer against each block with set inhibit on, then both blocks with set inhibit off
    for (int i = 0; i < 6; i++) begin
      wr({2'h0, i < 4, 9'h0, i[1], 3'h6});
      acc({6'h0, i[0], 14'h0}, 1'b0, '0, (i < 4 && i[1] == i[0]) ? 2'h0 : 2'h3);
    end
    $display("protect test done");
    wr(16'h0000);
    acc(a, 1'b0, {2'b10, 6'h00, 6'h03}, 2'h0);
    rd(16'h8ff0, {4'h0, a[17:11], 5'h10}, "low view");
    wr(16'h4000);
    acc(a, 1'b0, {2'b10, 6'h00, 6'h03}, 2'h0);
    rd(16'hcff0, {6'h10, a[1], a[21:18], 5'h10}, "high view");
    wr({6'h10, a[1], a[21:18], 5'h14});
    rd(16'hcff4, 16'h4074, "syndrome view");
    $display("logging test done");
    wr(16'h0000);
    acc(a, 1'b0, {2'b01, 12'h0}, 2'h0);
    rd(16'h8010, 16'h8000, "double error");
    wr(16'h0002);
    acc(a, 1'b0, {2'b10, 12'h0}, 2'h2);
    rd(16'h8012, 16'h8002, "single no corr");
    wr(16'h2002);
    acc(21'h0, 1'b0, {2'b10, 12'h0}, 2'h0);
    rd(16'ha012, 16'h2012, "protected single");
    $display("flag test done");
    // the mode in force before the write edge picks where bits 5-11 go
    wr(16'h0004);
    wr(16'h0aa4);
    rd(16'h0fe4, 16'h0aa4, "mf write");
    acc(a, 1'b0, {2'b00, 6'h2a, 6'h00}, 2'h1);
    rd(16'h07e0, 16'h0540, "check bits");
    acc(a, 1'b1, '0, 2'h1);
    chk("write check", 16'h002a, {10'h0, wr_check_ff});
    @(posedge sys_clk) #1 resetn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 resetn = 1'b1;
    rd(16'hffff, 16'h0000, "after reset");
    wr(16'h0004);
    rd(16'h0fe4, 16'h0544, "mf kept");
    $display("check bit test done");
    end_sim();
  end
endmodule
